/* File: rtl/sle_params.svh */
`ifndef SLE_PARAMS_SVH
`define SLE_PARAMS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define SLE_NUM_LINKS   2
`define SLE_PAGE_W      1
`define SLE_LANES       8
`define SLE_ADDR_W      14
// ----------------------------------------
// Register indices, byte address is 4x
// ----------------------------------------
`define SLE_IDX_PAGE    12'h300
`define SLE_IDX_ALIGN   12'h46C
`define SLE_IDX_DISP    12'h46D
`define SLE_IDX_CODE    12'h46E
`define SLE_IDX_LIMIT   12'h47A
`define SLE_IDX_CLEAR   12'h47B
`define SLE_IDX_IRQ_ST  12'h47C
`define SLE_IDX_IRQ_MSK 12'h47D
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SLE_IRQ_DISP    0
`define SLE_IRQ_CODE    1
`define SLE_IRQ_ALIGN   2
`define SLE_IRQ_W       3
`define SLE_CLEAR_BIT   0
`define SLE_LIMIT_RST   8'hFF
`define SLE_MASK_RST    3'h0
`define SLE_CNT_MAX     8'hFF
`endif

/* File: rtl/sle_pkg.sv */
package sle_pkg;
  `include "sle_params.svh"

  typedef logic [`SLE_LANES-1:0] sle_lane_t;
  typedef logic [7:0]            sle_byte_t;
  typedef sle_byte_t [`SLE_LANES-1:0] sle_cnt_t;

  typedef struct packed {
    logic [`SLE_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [3:0]             byteenable;
    logic [31:0]            writedata;
  } sle_av_req_t;

  typedef struct packed {
    sle_cnt_t  disp_cnt;
    sle_cnt_t  code_cnt;
    sle_lane_t align;
    sle_lane_t disp_flag;
    sle_lane_t code_flag;
  } sle_link_t;

  typedef sle_link_t [`SLE_NUM_LINKS-1:0] sle_links_t;
  typedef sle_lane_t [`SLE_NUM_LINKS-1:0] sle_lanes_t;

  typedef struct packed {
    sle_links_t              links;
    logic [`SLE_PAGE_W-1:0]  page;
    sle_byte_t               limit;
    logic [`SLE_IRQ_W-1:0]   irq_stat;
    logic [`SLE_IRQ_W-1:0]   irq_mask;
    logic                    ack;
    logic [31:0]             rdata;
  } sle_state_t;
endpackage

/* File: rtl/sle_status.sv */
`timescale 1ns/1ps
module sle_status
  import sle_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire sle_av_req_t av_req,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  input  wire sle_lanes_t  align_ok,
  input  wire sle_lanes_t  disp_err,
  input  wire sle_lanes_t  bad_code,
  output logic             irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sle_state_t st;
  sle_state_t next_st;

  logic [11:0] idx;
  logic        aligned_addr;
  logic        req;
  logic        wr_hit;
  logic        clr_hit;
  logic [31:0] rd_mux;
  sle_link_t   cur;

  assign idx          = av_req.address[`SLE_ADDR_W-1:2];
  assign aligned_addr = (av_req.address[1:0] == 2'h0);
  assign req          = av_req.read | av_req.write;
  // Write lands only on the edge where waitrequest is low
  assign wr_hit       = av_req.write & st.ack & aligned_addr & av_req.byteenable[0];
  assign clr_hit      = wr_hit & (idx == `SLE_IDX_CLEAR) & av_req.writedata[`SLE_CLEAR_BIT];
  assign cur          = st.links[st.page];

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aligned_addr) begin
      unique case (idx)
        `SLE_IDX_PAGE:    rd_mux[`SLE_PAGE_W-1:0] = st.page;
        `SLE_IDX_ALIGN:   rd_mux[7:0] = cur.align;
        `SLE_IDX_DISP:    rd_mux[7:0] = cur.disp_flag;
        `SLE_IDX_CODE:    rd_mux[7:0] = cur.code_flag;
        `SLE_IDX_LIMIT:   rd_mux[7:0] = st.limit;
        `SLE_IDX_IRQ_ST:  rd_mux[`SLE_IRQ_W-1:0] = st.irq_stat;
        `SLE_IDX_IRQ_MSK: rd_mux[`SLE_IRQ_W-1:0] = st.irq_mask;
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [`SLE_IRQ_W-1:0] ev;
    next_st = st;
    ev      = '0;
    // One wait cycle per request
    next_st.ack = req & ~st.ack;
    if (av_req.read & ~st.ack) begin
      next_st.rdata = rd_mux;
    end

    if (wr_hit) begin
      unique case (idx)
        `SLE_IDX_PAGE:    next_st.page = av_req.writedata[`SLE_PAGE_W-1:0];
        `SLE_IDX_LIMIT:   next_st.limit = av_req.writedata[7:0];
        `SLE_IDX_IRQ_MSK: next_st.irq_mask = av_req.writedata[`SLE_IRQ_W-1:0];
        `SLE_IDX_IRQ_ST:  next_st.irq_stat = st.irq_stat & ~av_req.writedata[`SLE_IRQ_W-1:0];
        default:          next_st.page = st.page;
      endcase
    end

    for (int l = 0; l < `SLE_NUM_LINKS; l++) begin
      next_st.links[l].align = align_ok[l];
      for (int n = 0; n < `SLE_LANES; n++) begin
        // Clear of the selected link restarts counting
        if (clr_hit && (st.page == l[`SLE_PAGE_W-1:0])) begin
          next_st.links[l].disp_cnt[n] = 8'h00;
          next_st.links[l].code_cnt[n] = 8'h00;
        end
        if (disp_err[l][n] && st.links[l].disp_cnt[n] != `SLE_CNT_MAX) begin
          next_st.links[l].disp_cnt[n] = next_st.links[l].disp_cnt[n] + 8'h01;
        end
        if (bad_code[l][n] && st.links[l].code_cnt[n] != `SLE_CNT_MAX) begin
          next_st.links[l].code_cnt[n] = next_st.links[l].code_cnt[n] + 8'h01;
        end
        next_st.links[l].disp_flag[n] = (next_st.links[l].disp_cnt[n] >= next_st.limit);
        next_st.links[l].code_flag[n] = (next_st.links[l].code_cnt[n] >= next_st.limit);
      end
      ev[`SLE_IRQ_DISP]  = ev[`SLE_IRQ_DISP]  | (|(next_st.links[l].disp_flag & ~st.links[l].disp_flag));
      ev[`SLE_IRQ_CODE]  = ev[`SLE_IRQ_CODE]  | (|(next_st.links[l].code_flag & ~st.links[l].code_flag));
      ev[`SLE_IRQ_ALIGN] = ev[`SLE_IRQ_ALIGN] | (|(st.links[l].align & ~align_ok[l]));
    end
    // Set wins over a same-cycle clear
    next_st.irq_stat = next_st.irq_stat | ev;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st          <= '0;
      st.limit    <= `SLE_LIMIT_RST;
      st.irq_mask <= `SLE_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign av_readdata    = st.rdata;
  assign av_waitrequest = req & ~st.ack;
  assign irq            = |(st.irq_stat & st.irq_mask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sle_lane_t chk_disp;
  sle_lane_t chk_code;
  always_comb begin
    for (int n = 0; n < `SLE_LANES; n++) begin
      chk_disp[n] = (cur.disp_cnt[n] >= st.limit);
      chk_code[n] = (cur.code_cnt[n] >= st.limit);
    end
  end

  align_track_a: assert property (
    align_ok[st.page] == cur.align |=> 1'b1 ##0 st.links[0].align == $past(align_ok[0]))
    else $error("alignment flag does not follow lane input");

  align_read_a: assert property (
    av_req.read && av_req.address == {`SLE_IDX_ALIGN, 2'b00} && !st.ack
      |=> av_readdata == {24'h0, $past(cur.align)} && !av_waitrequest)
    else $error("alignment register read wrong");

  disp_flag_a: assert property (cur.disp_flag == chk_disp)
    else $error("disparity flag disagrees with count");

  code_flag_a: assert property (cur.code_flag == chk_code)
    else $error("bad code flag disagrees with count");

  limit_equal_a: assert property (
    cur.disp_cnt[0] == st.limit |-> cur.disp_flag[0] && cur.disp_cnt[0] + 9'h001 > {1'b0, st.limit})
    else $error("count equal to limit not flagged");

  page_read_a: assert property (
    av_req.read && av_req.address == {`SLE_IDX_DISP, 2'b00} && !st.ack
      |=> av_readdata[7:0] == $past(st.links[st.page].disp_flag))
    else $error("read does not show selected link");

  flag_ro_a: assert property (
    wr_hit && idx == `SLE_IDX_CODE && !(|bad_code) && $stable(st.limit)
      |=> cur.code_flag == $past(cur.code_flag) || $past(st.page) != st.page)
    else $error("write changed a read only flag");

  sat_count_a: assert property (
    disp_err[0][0] && !clr_hit && st.links[0].disp_cnt[0] != `SLE_CNT_MAX
      |=> st.links[0].disp_cnt[0] == $past(st.links[0].disp_cnt[0]) + 8'h01)
    else $error("counter did not step by one");

  sat_hold_a: assert property (
    st.links[0].code_cnt[0] == `SLE_CNT_MAX && !clr_hit |=> st.links[0].code_cnt[0] == `SLE_CNT_MAX)
    else $error("counter wrapped");

  wait_one_a: assert property (req && av_waitrequest |=> !av_waitrequest)
    else $error("waitrequest held more than one cycle");

  irq_level_a: assert property ($rose(st.links[0].disp_flag[0]) |-> st.irq_stat[`SLE_IRQ_DISP])
    else $error("disparity event not latched");

  disp_hit_c:  cover property ($rose(cur.disp_flag[0]));
  code_hit_c:  cover property ($rose(cur.code_flag[7]));
  page_flip_c: cover property ($changed(st.page) ##[1:20] av_req.read && !av_waitrequest);
  irq_c:       cover property ($rose(irq));
  clear_c:     cover property (clr_hit);

  // ----------------------------------------
  // Per-lane checks
  // ----------------------------------------
  for (genvar k = 0; k < `SLE_NUM_LINKS; k++) begin : g_link
    for (genvar g = 0; g < `SLE_LANES; g++) begin : g_lane
      align_lane_a: assert property (
        st.links[k].align[g] == $past(align_ok[k][g]))
        else $error("lane alignment flag lags");

      disp_cmp_a: assert property (
        st.links[k].disp_flag[g] == (st.links[k].disp_cnt[g] >= st.limit))
        else $error("lane disparity flag wrong");

      code_cmp_a: assert property (
        st.links[k].code_flag[g] == (st.links[k].code_cnt[g] >= st.limit))
        else $error("lane bad code flag wrong");

      disp_step_a: assert property (
        disp_err[k][g] && !clr_hit && st.links[k].disp_cnt[g] != `SLE_CNT_MAX
          |=> st.links[k].disp_cnt[g] == $past(st.links[k].disp_cnt[g]) + 8'h01)
        else $error("lane disparity counter missed a step");

      code_step_a: assert property (
        bad_code[k][g] && !clr_hit && st.links[k].code_cnt[g] != `SLE_CNT_MAX
          |=> st.links[k].code_cnt[g] == $past(st.links[k].code_cnt[g]) + 8'h01)
        else $error("lane bad code counter missed a step");

      disp_sat_a: assert property (
        st.links[k].disp_cnt[g] == `SLE_CNT_MAX && !clr_hit
          |=> st.links[k].disp_cnt[g] == `SLE_CNT_MAX)
        else $error("lane disparity counter wrapped");

      disp_idle_a: assert property (
        !disp_err[k][g] && !clr_hit |=> $stable(st.links[k].disp_cnt[g]))
        else $error("lane disparity counter moved without error");
    end
  end

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  // bad code read path
  code_read_a: assert property (
    av_req.read && av_req.address == {`SLE_IDX_CODE, 2'h0} && !st.ack
      |=> av_readdata == {24'h00_0000, $past(cur.code_flag)})
    else $error("bad code register read wrong");

  limit_write_a: assert property (
    wr_hit && idx == `SLE_IDX_LIMIT |=> st.limit == $past(av_req.writedata[7:0]))
    else $error("limit write lost");

  page_write_a: assert property (
    wr_hit && idx == `SLE_IDX_PAGE
      |=> st.page == $past(av_req.writedata[`SLE_PAGE_W-1:0]))
    else $error("page write lost");

  // Unaligned reads give zero
  unmapped_read_a: assert property (
    av_req.read && !aligned_addr && !st.ack |=> av_readdata == 32'h0000_0000)
    else $error("unaligned read not zero");

  // Read data stands until next read
  rdata_hold_a: assert property (
    !(av_req.read && !st.ack) |=> $stable(av_readdata))
    else $error("read data changed without a read");

  // Lane byte off means no write
  be_ignore_a: assert property (
    av_req.write && st.ack && !av_req.byteenable[0] && idx == `SLE_IDX_LIMIT |=> $stable(st.limit))
    else $error("write with byte disabled landed");

  ack_idle_a: assert property (!req |=> !st.ack)
    else $error("acknowledge without request");

  // ----------------------------------------
  // Event checks
  // ----------------------------------------
  // clear zeroes counts
  clear_zero_a: assert property (
    clr_hit && !(|disp_err[st.page]) |=> cur.disp_cnt == '0)
    else $error("clear left a count");

  align_event_a: assert property (
    |(st.links[0].align & ~align_ok[0]) |=> st.irq_stat[`SLE_IRQ_ALIGN])
    else $error("alignment loss not latched");

  // Sticky until written one
  irq_sticky_a: assert property (
    st.irq_stat[`SLE_IRQ_CODE] && !(wr_hit && idx == `SLE_IDX_IRQ_ST)
      |=> st.irq_stat[`SLE_IRQ_CODE])
    else $error("status bit dropped by itself");

  irq_out_a: assert property (
    st.irq_stat[`SLE_IRQ_DISP] && st.irq_mask[`SLE_IRQ_DISP] |-> irq)
    else $error("unmasked status without interrupt");

endmodule // sle_status

/* File: sim/sle_lane_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Far-side lane source
// ----------------------------------------
module sle_lane_src
  import sle_pkg::*;
(
  input  wire logic clk_sys,
  output sle_lanes_t align_ok,
  output sle_lanes_t disp_err,
  output sle_lanes_t bad_code
);
  initial begin
    align_ok = '0;
    disp_err = '0;
    bad_code = '0;
  end
  task automatic set_align(input int link, input logic [7:0] v);
    align_ok[link] <= v;
  endtask
  // Held pulses count once per cycle high
  task automatic burst(input int link, input bit code, input logic [7:0] lanes, input int n);
    if (code) bad_code[link] <= lanes;
    else disp_err[link] <= lanes;
    repeat (n) @(posedge clk_sys);
    bad_code[link] <= '0;
    disp_err[link] <= '0;
    @(posedge clk_sys);
  endtask
endmodule // sle_lane_src

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "sle_params.svh"
module tb_top;
  import sle_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  sle_av_req_t av_req  = '0;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  logic        irq;
  sle_lanes_t  align_ok, disp_err, bad_code;
  logic [31:0] exp_q[$];
  logic [7:0]  rnd;
  int          err_total = 0;
  int          cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  sle_status sle_status_inst (.clk_sys(clk_sys), .arst_n(arst_n), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .align_ok(align_ok),
    .disp_err(disp_err), .bad_code(bad_code), .irq(irq));
  sle_lane_src sle_lane_src_inst (.clk_sys(clk_sys), .align_ok(align_ok),
    .disp_err(disp_err), .bad_code(bad_code));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read data taken only at the edge waitrequest is low
  always @(posedge clk_sys) begin
    if (av_req.read && av_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk(av_readdata, 32'hDEADBEEF);
      else chk(av_readdata, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Avalon master
  // ----------------------------------------
  function automatic logic [13:0] a(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic bus(input logic [13:0] ad, input logic wr, input logic [31:0] d);
    av_req <= '{address: ad, read: !wr, write: wr, byteenable: 4'hF, writedata: d};
    @(posedge clk_sys);
    while (av_waitrequest !== 1'b0) @(posedge clk_sys);
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [13:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(ad, 1'b0, 32'h0);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(66));
    rnd = $urandom;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(a(`SLE_IDX_ALIGN), 32'h0);
    rd(a(`SLE_IDX_DISP), 32'h0);
    rd(a(`SLE_IDX_CODE), 32'h0);
    bus(a(`SLE_IDX_DISP), 1'b1, 32'hFF);
    rd(a(`SLE_IDX_DISP), 32'h0);
    rd({`SLE_IDX_ALIGN, 2'b10}, 32'h0);
    $display("Test reset and read-only done");
    sle_lane_src_inst.set_align(0, 8'hFF);
    sle_lane_src_inst.set_align(1, rnd);
    bus(a(`SLE_IDX_LIMIT), 1'b1, 32'h3);
    sle_lane_src_inst.burst(0, 1'b0, 8'h08, 2);
    rd(a(`SLE_IDX_DISP), 32'h0);
    sle_lane_src_inst.burst(0, 1'b0, 8'h08, 1);
    rd(a(`SLE_IDX_DISP), 32'h08);
    sle_lane_src_inst.burst(0, 1'b1, 8'h80, 4);
    rd(a(`SLE_IDX_CODE), 32'h80);
    rd(a(`SLE_IDX_ALIGN), 32'hFF);
    $display("Test threshold done");
    bus(a(`SLE_IDX_PAGE), 1'b1, 32'h1);
    rd(a(`SLE_IDX_DISP), 32'h0);
    rd(a(`SLE_IDX_ALIGN), {24'h0, rnd});
    // Saturation shows as a flag kept at the top limit
    sle_lane_src_inst.burst(1, 1'b0, 8'h01, 300);
    bus(a(`SLE_IDX_LIMIT), 1'b1, 32'hFF);
    rd(a(`SLE_IDX_DISP), 32'h01);
    bus(a(`SLE_IDX_CLEAR), 1'b1, 32'h1);
    rd(a(`SLE_IDX_DISP), 32'h0);
    sle_lane_src_inst.set_align(0, 8'h0F);
    bus(a(`SLE_IDX_PAGE), 1'b1, 32'h0);
    rd(a(`SLE_IDX_ALIGN), 32'h0F);
    $display("Test page and saturation done");
    bus(a(`SLE_IDX_IRQ_MSK), 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(a(`SLE_IDX_IRQ_ST), 1'b1, 32'h7);
    chk({31'h0, irq}, 32'h0);
    $display("Test interrupt done");
    stop_test();
  end
  // Run is about 400 cycles
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
endmodule // tb_top
